/* File: shared/bit_exec_pkg.sv */
// Package with encodings, field positions and phase states of the bit instruction executor.
package bit_exec_pkg;

	localparam int INSTR_W       = 14;
	localparam int ADDR_W        = 7;
	localparam int BIDX_W        = 3;
	localparam int DATA_W        = 8;
	localparam int PREFIX_HI     = 13;
	localparam int PREFIX_LO     = 12;
	localparam int OPSEL_HI      = 11;
	localparam int OPSEL_LO      = 10;
	localparam int BIDX_HI       = 9;
	localparam int BIDX_LO       = 7;
	localparam int ADDR_HI       = 6;
	localparam int ADDR_LO       = 0;

	localparam logic [1:0] BIT_PREFIX   = 2'h1;
	localparam logic [1:0] OPSEL_CLEAR  = 2'h0;
	localparam logic [1:0] OPSEL_SET    = 2'h1;
	localparam logic [1:0] OPSEL_TEST   = 2'h2;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

	// Four internal phases of one instruction cycle, Gray coded.
	typedef enum logic [1:0] {
		PH_DECODE  = 2'b00,
		PH_READ    = 2'b01,
		PH_PROCESS = 2'b11,
		PH_WRITE   = 2'b10
	} phase_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_CLEAR,
		OP_SET,
		OP_TEST
	} bit_op_t;

	// File register access request toward the register file.
	typedef struct packed {
		logic              readEn;
		logic              writeEn;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} file_req_t;

endpackage

/* File: core/bit_oriented_instruction_exec.sv */
// Executor for the single-bit clear, set and test-skip-if-clear file register instructions.
`timescale 1ns/1ns
module bit_oriented_instruction_exec (
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rst,
	// Instruction stream, one word per instruction cycle, sampled at the decode phase
	input  wire logic [bit_exec_pkg::INSTR_W-1:0] instrWord,
	input  wire logic                         instrValid,
	// File register port
	output bit_exec_pkg::file_req_t           fileReq,
	input  wire logic [bit_exec_pkg::DATA_W-1:0] fileRdata,
	// Status
	output logic [1:0]                        phase,
	output logic                              cycleStart,
	output logic                              skipActive,
	output logic                              instrHandled
);
	import bit_exec_pkg::*;

	// Words outside the bit group, and the unused fourth selector, decode to no operation.
	// Such words pass through the four phases without touching the register file.
	function automatic bit_op_t decode_op(input logic [INSTR_W-1:0] w);
		bit_op_t op;
		op = OP_NONE;
		if (w[PREFIX_HI:PREFIX_LO] == BIT_PREFIX) begin
			unique case (w[OPSEL_HI:OPSEL_LO])
				OPSEL_CLEAR: op = OP_CLEAR;
				OPSEL_SET:   op = OP_SET;
				OPSEL_TEST:  op = OP_TEST;
				default:     op = OP_NONE;
			endcase
		end
		return op;
	endfunction

	// Operands are captured at decode and held for the rest of the instruction cycle.
	// The read data is kept in data_reg so the write phase sees a stable value.
	phase_t               phase_reg, phase_next;
	bit_op_t              op_reg, op_next;
	logic [ADDR_W-1:0]    addr_reg, addr_next;
	logic [BIDX_W-1:0]    bidx_reg, bidx_next;
	logic [DATA_W-1:0]    data_reg, data_next;
	logic                 skip_reg, skip_next;
	logic                 nop_reg, nop_next;
	file_req_t            req_reg, req_next;
	logic                 done_reg, done_next;

	always_comb begin
		phase_next = phase_reg;
		op_next    = op_reg;
		addr_next  = addr_reg;
		bidx_next  = bidx_reg;
		data_next  = data_reg;
		skip_next  = skip_reg;
		nop_next   = nop_reg;
		req_next   = '0;
		done_next  = 1'b0;
		unique case (phase_reg)
			PH_DECODE: begin
				phase_next = PH_READ;
				// A pending skip turns this whole cycle into a no-operation.
				nop_next  = skip_reg;
				skip_next = 1'b0;
				if (instrValid && !skip_reg) begin
					op_next   = decode_op(instrWord);
					bidx_next = instrWord[BIDX_HI:BIDX_LO];
					addr_next = instrWord[ADDR_HI:ADDR_LO];
				end else begin
					op_next = OP_NONE;
				end
			end
			PH_READ: begin
				phase_next = PH_PROCESS;
				// The request is registered, so it shows on the port during the process phase.
				// The register file answers combinationally in that same cycle.
				if (op_reg != OP_NONE) begin
					req_next.readEn = 1'b1;
					req_next.addr   = addr_reg;
				end
			end
			PH_PROCESS: begin
				phase_next = PH_WRITE;
				// Only the selected bit is altered; the other seven come back unchanged.
				// A test only looks at the bit and arms the skip for the next cycle.
				data_next  = fileRdata;
				unique case (op_reg)
					OP_CLEAR: data_next[bidx_reg] = 1'b0;
					OP_SET:   data_next[bidx_reg] = 1'b1;
					OP_TEST:  skip_next = ~fileRdata[bidx_reg];
					OP_NONE:  data_next = data_reg;
				endcase
			end
			PH_WRITE: begin
				phase_next = PH_DECODE;
				done_next  = (op_reg != OP_NONE);
				// The test never writes, so flags and the register are left alone.
				if (op_reg == OP_CLEAR || op_reg == OP_SET) begin
					req_next.writeEn = 1'b1;
					req_next.addr    = addr_reg;
					req_next.wdata   = data_reg;
				end
			end
		endcase
	end

	// A reset also drops a pending skip, so the first instruction after it always runs.
	// Every output but cycleStart, a decode of the phase register, is registered to keep the register file free of decode glitches.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase_reg <= PH_DECODE;
			op_reg    <= OP_NONE;
			addr_reg  <= ADDR_RESET;
			bidx_reg  <= '0;
			data_reg  <= DATA_RESET;
			skip_reg  <= 1'b0;
			nop_reg   <= 1'b0;
			req_reg   <= '0;
			done_reg  <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			op_reg    <= op_next;
			addr_reg  <= addr_next;
			bidx_reg  <= bidx_next;
			data_reg  <= data_next;
			skip_reg  <= skip_next;
			nop_reg   <= nop_next;
			req_reg   <= req_next;
			done_reg  <= done_next;
		end
	end

	// The write of a clear or set lands in the decode phase of the following cycle.
	// This one-cycle lag is the price of registering the request.
	assign fileReq      = req_reg;
	assign phase        = phase_reg;
	assign cycleStart   = (phase_reg == PH_DECODE);
	assign skipActive   = nop_reg;
	assign instrHandled = done_reg;

	// Checks below follow one instruction from its decode edge to the write a cycle later.
	// Expected data is rebuilt from the sampled read value, not from the internal data path.
	// The reset check has no disable clause, since it watches the reset itself.
	// A cycle counted from the decode edge: read shows at +2, write at +4.

	a_clear_write: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_DECODE && instrValid && !skip_reg && decode_op(instrWord) == OP_CLEAR)
		##3 1 |=> (fileReq.writeEn && fileReq.wdata == ($past(fileRdata, 2) & ~(8'h01 << $past(bidx_reg, 2)))))
		else $error("bit clear wrote wrong value");

	a_set_write: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_DECODE && instrValid && !skip_reg && decode_op(instrWord) == OP_SET)
		##3 1 |=> (fileReq.writeEn && fileReq.wdata == ($past(fileRdata, 2) | (8'h01 << $past(bidx_reg, 2)))))
		else $error("bit set wrote wrong value");

	a_set_addr: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_DECODE && instrValid && !skip_reg
			&& instrWord[PREFIX_HI:OPSEL_LO] == {BIT_PREFIX, OPSEL_SET})
		|=> ##3 (fileReq.writeEn && fileReq.addr == $past(instrWord[ADDR_HI:ADDR_LO], 4)))
		else $error("bit set address wrong");

	a_test_noskip: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_PROCESS && op_reg == OP_TEST && fileRdata[bidx_reg]) |=> ##2 !skipActive)
		else $error("skip taken on set bit");

	a_handled_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_WRITE && op_reg != OP_NONE) |=> (instrHandled && cycleStart) ##1 !instrHandled)
		else $error("handled pulse wrong");

	a_test_skip: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_PROCESS && op_reg == OP_TEST && !fileRdata[bidx_reg])
		|=> ##2 (skipActive && op_reg == OP_NONE) [*4])
		else $error("skip cycle not a no-operation");

	a_skip_hold: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(skipActive) |-> (phase_reg == PH_READ) ##1 skipActive [*3] ##1 !skipActive)
		else $error("skip cycle length wrong");

	a_skip_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		skipActive |-> (!fileReq.writeEn && !fileReq.readEn))
		else $error("file access during skip");

	a_reset_idle: assert property (@(posedge ref_clk)
		rst |=> (phase_reg == PH_DECODE && fileReq == '0 && !skipActive && !instrHandled))
		else $error("reset state wrong");

	a_test_nowrite: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_WRITE && op_reg == OP_TEST) |=> !fileReq.writeEn)
		else $error("test instruction wrote register");

	a_ignore_other: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_DECODE && instrValid && decode_op(instrWord) == OP_NONE)
		|=> ##1 !fileReq.readEn ##2 !fileReq.writeEn)
		else $error("ignored word reached the file");

	a_phase_walk: assert property (@(posedge ref_clk) disable iff (rst)
		cycleStart |=> phase == 2'b01 ##1 phase == 2'b11 ##1 phase == 2'b10 ##1 cycleStart)
		else $error("phase sequence broken");

	a_read_addr: assert property (@(posedge ref_clk) disable iff (rst)
		(phase_reg == PH_DECODE && instrValid && !skip_reg && decode_op(instrWord) != OP_NONE)
		|=> ##1 (fileReq.readEn && fileReq.addr == $past(instrWord[ADDR_HI:ADDR_LO], 2)))
		else $error("read address wrong");

	// Main scenarios the bench is expected to reach.
	c_clear: cover property (@(posedge ref_clk) fileReq.writeEn && !fileReq.wdata[0]);
	c_skip: cover property (@(posedge ref_clk) skipActive);
	c_noskip: cover property (@(posedge ref_clk) phase_reg == PH_WRITE && op_reg == OP_TEST && !skip_reg);
	c_set: cover property (@(posedge ref_clk) phase_reg == PH_WRITE && op_reg == OP_SET);
	c_ignored: cover property (@(posedge ref_clk) phase_reg == PH_DECODE && instrValid && decode_op(instrWord) == OP_NONE);
endmodule

/* File: testbench/bit_oriented_instruction_exec_tb.sv */
// Self-checking bench for the bit instruction executor.
`timescale 1ns/1ns
module bit_oriented_instruction_exec_tb;
	import bit_exec_pkg::*;
	typedef struct packed {
		logic [INSTR_W-1:0] word;
		logic               vld;
		logic [DATA_W-1:0]  rdata;
		logic               rd;
		logic               wr;
		logic [DATA_W-1:0]  wdata;
		logic               skip;
	} row_t;
	logic               ref_clk = 1'b0;
	logic               rst = 1'b1;
	logic [INSTR_W-1:0] instrWord = 14'h0000;
	logic               instrValid = 1'b0;
	logic [DATA_W-1:0]  fileRdata = 8'h00;
	file_req_t          fileReq;
	logic [1:0]         phase;
	logic               cycleStart;
	logic               skipActive;
	logic               instrHandled;
	logic               prevHandled = 1'b0;
	logic               prevSkip = 1'b0;
	logic               prevNop = 1'b0;
	logic               prevWr = 1'b0;
	logic [DATA_W-1:0]  prevWdata = 8'h00;
	logic [ADDR_W-1:0]  prevAddr = 7'h00;
	int                 bad_count = 0;
	int                 num_checks = 0;
	row_t               rows [10];
	bit_oriented_instruction_exec u_bit_oriented_instruction_exec (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.instrWord   (instrWord),
		.instrValid  (instrValid),
		.fileReq     (fileReq),
		.fileRdata   (fileRdata),
		.phase       (phase),
		.cycleStart  (cycleStart),
		.skipActive  (skipActive),
		.instrHandled(instrHandled)
	);
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// The write and done pulse of one instruction show in the decode phase of the next, so a row checks its predecessor there.
	task automatic exec(input row_t r);
		while (phase !== 2'b10) @(negedge ref_clk);
		@(posedge ref_clk);
		instrWord <= r.word;
		instrValid <= r.vld;
		@(negedge ref_clk);
		chk(instrHandled, prevHandled);
		chk(fileReq.writeEn, prevWr);
		if (prevWr) chk({fileReq.addr, fileReq.wdata}, {prevAddr, prevWdata});
		chk(skipActive, prevNop);
		@(posedge ref_clk);
		fileRdata <= r.rdata;
		instrValid <= 1'b0;
		@(negedge ref_clk);
		chk(phase, 2'b01);
		chk(skipActive, prevSkip);
		@(negedge ref_clk);
		chk(fileReq.readEn, r.rd);
		if (r.rd) chk(fileReq.addr, r.word[6:0]);
		@(negedge ref_clk);
		chk(fileReq.writeEn, 1'b0);
		prevHandled = r.rd;
		prevNop = prevSkip;
		prevSkip = r.skip;
		prevWr = r.wr;
		prevWdata = r.wdata;
		prevAddr = r.word[6:0];
	endtask
	initial begin
		rows = '{
			'{14'h13ff, 1'b1, 8'hc7, 1'b1, 1'b1, 8'h47, 1'b0},
			'{14'h17a5, 1'b1, 8'h0a, 1'b1, 1'b1, 8'h8a, 1'b0},
			'{14'h1400, 1'b1, 8'hfe, 1'b1, 1'b1, 8'hff, 1'b0},
			'{14'h1883, 1'b1, 8'h02, 1'b1, 1'b0, 8'h00, 1'b0},
			'{14'h1bff, 1'b1, 8'h7f, 1'b1, 1'b0, 8'h00, 1'b1},
			'{14'h1400, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
			'{14'h1000, 1'b1, 8'hff, 1'b1, 1'b1, 8'hfe, 1'b0},
			'{14'h1c00, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
			'{14'h0000, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
			'{14'h1400, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0}};
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk({phase, skipActive, instrHandled}, 24'h000000);
		chk(fileReq, 24'h000000);
		foreach (rows[i]) exec(rows[i]);
		exec(rows[9]);
		// A reset during the replaced cycle must drop the pending skip.
		exec(rows[4]);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk({phase, skipActive, instrHandled}, 24'h000000);
		chk(fileReq, 24'h000000);
		prevHandled = 1'b0;
		prevSkip = 1'b0;
		prevNop = 1'b0;
		prevWr = 1'b0;
		exec(rows[1]);
		exec(rows[9]);
		give_verdict();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		bad_count++;
		give_verdict();
	end
endmodule
